// file: rtl/pwfo_channel.sv
`timescale 1ns/1ps
`include "pwfo_defines.svh"
module pwfo_channel
  import pwfo_pkg::*;
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         arst_n,
  // Host run state
  input  wire logic         host_stop,
  // Control interface
  input  wire pwfo_ctrl_t   ctrl,
  // Parameter record access
  input  wire logic         record_write_instr,
  input  wire logic         record_read_instr,
  input  wire logic [7:0]   record_num,
  input  wire pwfo_cfg_t    record_wdata,
  output pwfo_cfg_t         record_rdata_q,
  output logic              record_err_q,
  // Feedback
  output pwfo_status_t      status_q,
  // Output lines
  output logic              fast_output_line,
  output logic              standard_output_line
);

  pwfo_cfg_t    cfg_q;
  pwfo_state_t  state_q;
  logic [3:0]   div_q;
  logic         us_tick;
  logic [23:0]  period_q;
  logic [23:0]  per_pend_q;
  logic [23:0]  cnt_q;
  logic [23:0]  high_q;
  logic         run_req_q;
  logic         wave_q;
  logic         pulse_out_pin;
  logic [23:0]  per_min;
  logic [23:0]  per_clip;
  logic [15:0]  fs;
  logic [39:0]  prod;
  logic [23:0]  high_raw;
  logic [23:0]  high_d;
  logic         at_end;
  logic         rise;

  assign us_tick = (div_q == `PWFO_US_DIV);
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      div_q <= 4'h0;
    else
      div_q <= us_tick ? 4'h0 : div_q + 4'h1;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_q <= '{freq_mode: 1'b0, high_speed: 1'b0, line_std: 1'b0, stop_continue: 1'b0,
                 stop_subst: 1'b0, fmt: PWFO_FMT_PCT, min_pulse_us: `PWFO_MINPULSE_RST,
                 period_us: `PWFO_PERIOD_RST};
      record_rdata_q <= '0;
      record_err_q   <= 1'b0;
    end
    else
    begin
      if ((record_write_instr || record_read_instr) && record_num != `PWFO_RECORD_NUM)
        record_err_q <= 1'b1;
      else if (record_write_instr || record_read_instr)
        record_err_q <= 1'b0;
      if (record_write_instr && record_num == `PWFO_RECORD_NUM && state_q != PWFO_ST_RUN)
        cfg_q <= record_wdata;
      if (record_read_instr && record_num == `PWFO_RECORD_NUM)
        record_rdata_q <= cfg_q;
    end
  end

  always_comb
  begin
    if (cfg_q.line_std)
      per_min = cfg_q.freq_mode ? `PWFO_HALF_MIN_STD + `PWFO_HALF_MIN_STD : `PWFO_PER_MIN_STD;
    else if (cfg_q.high_speed)
      per_min = cfg_q.freq_mode ? `PWFO_HALF_MIN_HS + `PWFO_HALF_MIN_HS : `PWFO_PER_MIN_HS;
    else
      per_min = cfg_q.freq_mode ? `PWFO_HALF_MIN_FAST + `PWFO_HALF_MIN_FAST : `PWFO_PER_MIN_FAST;
    if (per_pend_q > `PWFO_PERIOD_MAX)
      per_clip = `PWFO_PERIOD_MAX;
    else if (per_pend_q < per_min)
      per_clip = per_min;
    else
      per_clip = per_pend_q;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      per_pend_q <= `PWFO_PERIOD_RST;
    end
    else if (ctrl.period_wr)
    begin
      per_pend_q <= ctrl.period_us;
    end
    else if (record_write_instr && record_num == `PWFO_RECORD_NUM && state_q != PWFO_ST_RUN)
    begin
      per_pend_q <= record_wdata.period_us;
    end
  end

  // Ratio full scale per format
  always_comb
  begin
    unique case (cfg_q.fmt)
      PWFO_FMT_PERMIL:  fs = `PWFO_FS_PERMIL;
      PWFO_FMT_PERTENK: fs = `PWFO_FS_PERTENK;
      PWFO_FMT_ANALOG:  fs = `PWFO_FS_ANALOG;
      PWFO_FMT_PCT:     fs = `PWFO_FS_PCT;
    endcase
    prod = per_clip * ctrl.ratio;
    high_raw = 24'(prod / fs);
    if (ctrl.ratio >= fs)
      high_raw = per_clip;
    if (cfg_q.freq_mode)
      high_raw = {1'b0, per_clip[23:1]};
    if (high_raw < cfg_q.min_pulse_us)
      high_d = 24'h0;
    else if (per_clip - high_raw < cfg_q.min_pulse_us)
      high_d = per_clip;
    else
      high_d = high_raw;
  end

  assign at_end = (cnt_q + 24'h1 >= period_q);
  assign rise   = ctrl.sw_run_request && !run_req_q;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      run_req_q <= 1'b0;
    else
      run_req_q <= ctrl.sw_run_request;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      state_q <= PWFO_ST_IDLE;
    else
      unique case (state_q)
        PWFO_ST_IDLE:  state_q <= rise ? PWFO_ST_RUN : PWFO_ST_IDLE;
        PWFO_ST_RUN:   state_q <= ctrl.sw_run_request ? PWFO_ST_RUN : PWFO_ST_ABORT;
        PWFO_ST_ABORT: state_q <= rise ? PWFO_ST_RUN : PWFO_ST_ABORT;
        default:       state_q <= PWFO_ST_IDLE;
      endcase
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q    <= 24'h0;
      period_q <= `PWFO_PERIOD_RST;
      high_q   <= 24'h0;
      wave_q   <= 1'b0;
    end
    else if (state_q != PWFO_ST_RUN || !ctrl.sw_run_request)
    begin
      cnt_q    <= 24'h0;
      period_q <= per_clip;
      high_q   <= high_d;
      wave_q   <= 1'b0;
    end
    else if (us_tick)
    begin
      // New values taken at period start
      if (at_end)
      begin
        cnt_q    <= 24'h0;
        period_q <= per_clip;
        high_q   <= high_d;
        wave_q   <= (high_d != 24'h0);
      end
      else
      begin
        cnt_q  <= cnt_q + 24'h1;
        wave_q <= (cnt_q + 24'h1 < high_q);
      end
    end
    else if (cnt_q == 24'h0)
      wave_q <= (high_q != 24'h0);
  end

  // Output selection
  always_comb
  begin
    if (ctrl.generator_owns_output)
      pulse_out_pin = wave_q && ctrl.sw_run_request && state_q == PWFO_ST_RUN;
    else
      pulse_out_pin = ctrl.manual_output_level;
    if (host_stop && !cfg_q.stop_continue)
      pulse_out_pin = cfg_q.stop_subst;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fast_output_line     <= 1'b0;
      standard_output_line <= 1'b0;
      status_q             <= '0;
    end
    else
    begin
      fast_output_line     <= !cfg_q.line_std && pulse_out_pin;
      standard_output_line <= cfg_q.line_std && pulse_out_pin;
      status_q.run_request_echo     <= ctrl.sw_run_request;
      status_q.sequence_active_flag <= (state_q == PWFO_ST_RUN || rise) && ctrl.sw_run_request;
      status_q.out_level            <= pulse_out_pin;
    end
  end

  a_abort_clears: assert property (@(posedge mclk) disable iff (!arst_n)
    (state_q == PWFO_ST_RUN && !ctrl.sw_run_request && ctrl.generator_owns_output && !host_stop)
      |=> !status_q.sequence_active_flag && !status_q.out_level) else $error("abort not cleared");
  a_abort_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
    (state_q == PWFO_ST_ABORT && !rise) |=> state_q != PWFO_ST_RUN) else $error("restart without edge");
  a_rise_starts: assert property (@(posedge mclk) disable iff (!arst_n)
    rise |=> state_q == PWFO_ST_RUN && status_q.sequence_active_flag) else $error("run not started");
  a_manual_level: assert property (@(posedge mclk) disable iff (!arst_n)
    (!ctrl.generator_owns_output && !host_stop) |=> status_q.out_level == $past(ctrl.manual_output_level))
    else $error("manual level wrong");
  a_echo_follow: assert property (@(posedge mclk) disable iff (!arst_n)
    ##1 status_q.run_request_echo == $past(ctrl.sw_run_request)) else $error("echo wrong");
  a_stop_subst: assert property (@(posedge mclk) disable iff (!arst_n)
    (host_stop && !cfg_q.stop_continue) |=> status_q.out_level == $past(cfg_q.stop_subst))
    else $error("stop level wrong");
  a_us_period: assert property (@(posedge mclk) disable iff (!arst_n)
    us_tick |=> !us_tick [*8] ##1 !us_tick ##1 us_tick) else $error("timebase wrong");
  a_line_route: assert property (@(posedge mclk) disable iff (!arst_n)
    !(fast_output_line && standard_output_line)) else $error("both lines driven");
  a_period_range: assert property (@(posedge mclk) disable iff (!arst_n)
    period_q <= `PWFO_PERIOD_MAX) else $error("period over limit");
  a_record_refused: assert property (@(posedge mclk) disable iff (!arst_n)
    (record_write_instr && state_q == PWFO_ST_RUN) |=> $stable(cfg_q)) else $error("record taken in run");
  a_record_number: assert property (@(posedge mclk) disable iff (!arst_n)
    ((record_write_instr || record_read_instr) && record_num != `PWFO_RECORD_NUM) |=> record_err_q)
    else $error("record number not flagged");
  a_zero_low: assert property (@(posedge mclk) disable iff (!arst_n)
    (state_q == PWFO_ST_RUN && high_q == 24'h0 && !(us_tick && at_end)) |=> !wave_q)
    else $error("pulse with zero high time");
  a_owner_wave: assert property (@(posedge mclk) disable iff (!arst_n)
    (ctrl.generator_owns_output && !host_stop && state_q == PWFO_ST_RUN && ctrl.sw_run_request)
      |=> status_q.out_level == $past(wave_q)) else $error("generator level wrong");
  // Standard route keeps fast line low
  a_std_route: assert property (@(posedge mclk) disable iff (!arst_n)
    cfg_q.line_std |=> !fast_output_line) else $error("fast line driven on standard route");
  a_period_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    (state_q == PWFO_ST_RUN && ctrl.sw_run_request && !(us_tick && at_end)) |=> $stable(period_q))
    else $error("period changed mid-period");
  a_flag_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    (state_q == PWFO_ST_RUN && ctrl.sw_run_request) |=> status_q.sequence_active_flag)
    else $error("flag dropped");

  c_run_start: cover property (@(posedge mclk) disable iff (!arst_n) rise);
  c_abort:     cover property (@(posedge mclk) disable iff (!arst_n) state_q == PWFO_ST_ABORT);
  c_pulse:     cover property (@(posedge mclk) disable iff (!arst_n) $rose(wave_q));
  c_freq:      cover property (@(posedge mclk) disable iff (!arst_n) cfg_q.freq_mode && wave_q);
  c_stop_hold: cover property (@(posedge mclk) disable iff (!arst_n) host_stop && cfg_q.stop_continue);
endmodule : pwfo_channel

// file: rtl/pwfo_defines.svh
`ifndef PWFO_DEFINES_SVH
`define PWFO_DEFINES_SVH
`define PWFO_CLK_MHZ        10
`define PWFO_US_DIV         4'h9
`define PWFO_PERIOD_RST     24'h1e8480
`define PWFO_PERIOD_MAX     24'h989680
`define PWFO_PER_MIN_HS     24'h00000a
`define PWFO_PER_MIN_FAST   24'h000064
`define PWFO_PER_MIN_STD    24'h002710
`define PWFO_HALF_MIN_HS    24'h000002
`define PWFO_HALF_MIN_FAST  24'h000032
`define PWFO_HALF_MIN_STD   24'h001388
`define PWFO_MINPULSE_RST   24'h000000
`define PWFO_FS_PCT         16'h0064
`define PWFO_FS_PERMIL      16'h03e8
`define PWFO_FS_PERTENK     16'h2710
`define PWFO_FS_ANALOG      16'h6c00
`define PWFO_RECORD_NUM     8'h80
`endif

// file: rtl/pwfo_pkg.sv
package pwfo_pkg;
  typedef enum logic [1:0] {
    PWFO_FMT_PCT    = 2'h0,
    PWFO_FMT_PERMIL = 2'h1,
    PWFO_FMT_PERTENK = 2'h2,
    PWFO_FMT_ANALOG = 2'h3
  } pwfo_fmt_t;

  typedef enum logic [2:0] {
    PWFO_ST_IDLE  = 3'b001,
    PWFO_ST_RUN   = 3'b010,
    PWFO_ST_ABORT = 3'b100
  } pwfo_state_t;

  // Parameter record carried by a record write
  typedef struct packed {
    logic        freq_mode;
    logic        high_speed;
    logic        line_std;
    logic        stop_continue;
    logic        stop_subst;
    pwfo_fmt_t   fmt;
    logic [23:0] min_pulse_us;
    logic [23:0] period_us;
  } pwfo_cfg_t;

  // Control interface, written by the program's tasks and held between them
  typedef struct packed {
    logic        sw_run_request;
    logic        generator_owns_output;
    logic        manual_output_level;
    logic        period_wr;
    logic [23:0] period_us;
    logic [15:0] ratio;
  } pwfo_ctrl_t;

  typedef struct packed {
    logic run_request_echo;
    logic sequence_active_flag;
    logic out_level;
  } pwfo_status_t;
endpackage : pwfo_pkg

// file: tb/pwfo_prog_model.sv
`timescale 1ns/1ps
module pwfo_prog_model
  import pwfo_pkg::*;
(
  // Clock
  input  wire logic  mclk,
  // Requests to the channel
  output pwfo_ctrl_t ctrl,
  output logic       record_write_instr,
  output logic       record_read_instr,
  output logic [7:0] record_num,
  output pwfo_cfg_t  record_wdata
);
  initial
  begin
    ctrl = '0;
    record_write_instr = 1'b0;
    record_read_instr = 1'b0;
    record_num = 8'h80;
    record_wdata = '0;
  end
  task automatic run(input logic on);
    @(posedge mclk);
    #1 ctrl.sw_run_request = on;
  endtask : run
  task automatic ctl(input logic owns, input logic lvl, input logic [15:0] ratio);
    @(posedge mclk);
    #1 ctrl.generator_owns_output = owns;
    ctrl.manual_output_level = lvl;
    ctrl.ratio = ratio;
  endtask : ctl
  task automatic per(input logic [23:0] p);
    @(posedge mclk);
    #1 ctrl.period_wr = 1'b1;
    ctrl.period_us = p;
    @(posedge mclk);
    #1 ctrl.period_wr = 1'b0;
    ctrl.period_us = ~p;
  endtask : per
  task automatic rec(input logic wr, input logic [7:0] num, input pwfo_cfg_t cfg);
    @(posedge mclk);
    #1 record_num = num;
    record_wdata = cfg;
    record_write_instr = wr;
    record_read_instr = !wr;
    @(posedge mclk);
    #1 record_write_instr = 1'b0;
    record_read_instr = 1'b0;
    record_wdata = ~cfg;
    repeat (2) @(posedge mclk);
  endtask : rec
endmodule : pwfo_prog_model

// file: tb/pulse_width_and_frequency_output_test.sv
`timescale 1ns/1ps
module pulse_width_and_frequency_output_test;
  import pwfo_pkg::*;
  typedef struct {pwfo_fmt_t fmt; logic [15:0] ratio; logic [23:0] minp; logic freq; int high;} pwfo_row_t;
  logic         mclk;
  logic         arst_n;
  logic         host_stop;
  pwfo_ctrl_t   ctrl;
  logic         wr;
  logic         rd;
  logic [7:0]   num;
  pwfo_cfg_t    wdata;
  pwfo_cfg_t    rdata;
  logic         err;
  pwfo_status_t st;
  logic         fast;
  logic         std_line;
  int           fail_count = 0;
  int           comparisons = 0;
  int           hi;
  pwfo_row_t    rows [8];
  pwfo_row_t    hs_row;

  pwfo_prog_model prog (.mclk(mclk), .ctrl(ctrl), .record_write_instr(wr), .record_read_instr(rd),
                        .record_num(num), .record_wdata(wdata));
  pwfo_channel uut (.mclk(mclk), .arst_n(arst_n), .host_stop(host_stop), .ctrl(ctrl),
                    .record_write_instr(wr), .record_read_instr(rd), .record_num(num),
                    .record_wdata(wdata), .record_rdata_q(rdata), .record_err_q(err), .status_q(st),
                    .fast_output_line(fast), .standard_output_line(std_line));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task automatic chk_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk_bit

  task automatic chk_cnt(input int got, input int exp, input string what);
    comparisons++;
    if (got != exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s high %0d want %0d", $time, what, got, exp);
    end
  endtask : chk_cnt

  task automatic chk_cfg(input pwfo_cfg_t got, input pwfo_cfg_t exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: record readback %h", $time, got);
    end
  endtask : chk_cfg

  // Counts high cycles of the fast line
  task automatic measure(input int n);
    hi = 0;
    repeat (n)
    begin
      @(posedge mclk);
      #1 if (fast === 1'b1) hi++;
    end
  endtask : measure

  // Idle, load a 100 us record with {high-speed, standard, continue, substitute}, then start
  task automatic start(input pwfo_row_t r, input logic [3:0] opt);
    prog.run(1'b0);
    prog.rec(1'b1, 8'h80, pwfo_cfg_t'{r.freq, opt[3], opt[2], opt[1], opt[0], r.fmt, r.minp, 24'h000064});
    prog.ctl(1'b1, 1'b0, r.ratio);
    prog.run(1'b1);
    repeat (1100) @(posedge mclk);
    #1;
  endtask : start

  initial
  begin
    #6000000;
    fail_count++;
    $display("unexpected at %0t: watchdog", $time);
    results();
  end

  initial
  begin
    arst_n = 1'b0;
    host_stop = 1'b0;
    rows[0] = '{PWFO_FMT_PCT, 16'h0032, 24'h0, 1'b0, 500};
    rows[1] = '{PWFO_FMT_PERMIL, 16'h00fa, 24'h0, 1'b0, 250};
    rows[2] = '{PWFO_FMT_PERTENK, 16'h03e8, 24'h0, 1'b0, 100};
    rows[3] = '{PWFO_FMT_ANALOG, 16'h6c00, 24'h0, 1'b0, 1000};
    rows[4] = '{PWFO_FMT_PERMIL, 16'h04b0, 24'h0, 1'b0, 1000};
    rows[5] = '{PWFO_FMT_PERMIL, 16'h0000, 24'h0, 1'b0, 0};
    rows[6] = '{PWFO_FMT_PERMIL, 16'h00fa, 24'h00001e, 1'b0, 0};
    rows[7] = '{PWFO_FMT_PCT, 16'h000a, 24'h0, 1'b1, 500};
    hs_row = '{PWFO_FMT_PCT, 16'h0032, 24'h000006, 1'b0, 0};
    repeat (20) @(posedge mclk);
    chk_bit(fast | std_line | (|st), 1'b0, "outputs in reset");
    #1 arst_n = 1'b1;
    prog.rec(1'b0, 8'h80, '0);
    chk_cfg(rdata, pwfo_cfg_t'{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, PWFO_FMT_PCT, 24'h0, 24'h1e8480});
    prog.rec(1'b0, 8'h7f, '0);
    chk_bit(err, 1'b1, "wrong record number");
    $display("reset and record test done");
    prog.ctl(1'b0, 1'b1, 16'h0);
    repeat (2) @(posedge mclk);
    #1 chk_bit(fast, 1'b1, "manual high");
    chk_bit(std_line, 1'b0, "unused line");
    $display("manual test done");
    foreach (rows[i])
    begin
      start(rows[i], 4'h0);
      measure(1000);
      chk_cnt(hi, rows[i].high, "row");
      $display("row %0d done", i);
    end
    start(rows[0], 4'h0);
    chk_bit(st.run_request_echo & st.sequence_active_flag, 1'b1, "run status");
    prog.rec(1'b1, 8'h80, '0);
    prog.rec(1'b0, 8'h80, '0);
    chk_cfg(rdata, pwfo_cfg_t'{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, PWFO_FMT_PCT, 24'h0, 24'h000064});
    prog.per(24'h0000c8);
    repeat (2200) @(posedge mclk);
    measure(2000);
    chk_cnt(hi, 1000, "new period");
    repeat (2000) if (fast !== 1'b0) @(negedge mclk);
    repeat (2000) if (fast !== 1'b1) @(negedge mclk);
    prog.run(1'b0);
    chk_bit(fast, 1'b1, "high before abort");
    @(posedge mclk);
    #1 chk_bit(st.sequence_active_flag | fast, 1'b0, "abort");
    measure(2000);
    chk_cnt(hi, 0, "after abort");
    $display("period and abort test done");
    start(rows[5], 4'h1);
    host_stop = 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk_bit(fast, 1'b1, "stop substitute");
    host_stop = 1'b0;
    start(rows[0], 4'h2);
    host_stop = 1'b1;
    measure(1000);
    chk_cnt(hi, 500, "stop continue");
    host_stop = 1'b0;
    $display("stop test done");
    start(rows[4], 4'h4);
    chk_bit(std_line, 1'b1, "standard line");
    chk_bit(fast, 1'b0, "fast line on standard route");
    start(hs_row, 4'h8);
    prog.per(24'h00000a);
    repeat (2200) @(posedge mclk);
    measure(1000);
    chk_cnt(hi, 0, "high-speed period");
    $display("option test done");
    results();
  end
endmodule : pulse_width_and_frequency_output_test
